// ---- crdec_core.sv ----
`timescale 1ns/1ps

module crdec_core (
   input  wire logic                           clk_sys,
   input  wire logic                           nrst,
   // Switch banks, sampled once after reset
   input  wire logic [crdec_pkg::SW_W-1:0]     level_sw,
   input  wire logic [crdec_pkg::SW_W-1:0]     offset_sw,
   input  wire logic [7:0]                     cfg_sw,
   // Events from the card
   input  wire logic                           ctrl_rst_evt,
   input  wire logic                           take_req,
   input  wire logic                           vi_pulse,
   // Register port
   input  wire logic [crdec_pkg::ADDR_W-1:0]   reg_addr,
   input  wire logic [crdec_pkg::DATA_W-1:0]   reg_wdata,
   input  wire logic                           reg_wr,
   input  wire logic                           reg_rd,
   output logic      [crdec_pkg::DATA_W-1:0]   reg_rdata,
   // Decoded configuration
   output logic      [crdec_pkg::LEVEL_W-1:0]  level,
   output logic      [crdec_pkg::BASE_W-1:0]   io_base,
   output logic                                ctrl_role,
   output logic                                crosspoint_reset_follow,
   output logic                                ctrl_port_en,
   output logic                                ref_in_use,
   output logic                                cfg_loaded,
   // Crosspoint control
   output logic                                xp_clear,
   output logic                                xp_valid,
   output logic                                xp_take
);
   import crdec_pkg::*;

   typedef struct packed {
      logic               loaded;
      logic [LEVEL_W-1:0] level;
      logic [SW_W-1:0]    offset;
      logic [BASE_W-1:0]  io_base;
      logic               role;
      logic               follow;
      logic               port_en;
      logic               ref_use;
      logic               xp_clear;
      logic               xp_valid;
      logic [DATA_W-1:0]  rdata;
   } crdec_core_s;

   crdec_core_s st;
   crdec_core_s next_st;

   logic wr_config;
   logic crst_any;
   logic refresh_any;
   logic take_any;
   logic clear_hit;
   logic sched_take;
   logic sched_pending;

   // Command strobes decoded from a CONTROL write, ORed with the matching input events
   assign wr_config   = reg_wr && (reg_addr == REG_CONTROL);
   assign crst_any    = ctrl_rst_evt || (wr_config && reg_wdata[CTL_CRST_BIT]);
   assign refresh_any = wr_config && reg_wdata[CTL_REFRESH_BIT];
   assign take_any    = take_req || (wr_config && reg_wdata[CTL_TAKE_BIT]);

   // Follow only counts in the controller role, so a stray switch on a
   // crosspoint-only card cannot wipe the matrix
   assign clear_hit = st.loaded && st.role && st.follow && crst_any;

   // Next state
   always_comb begin
      next_st = st;
      next_st.xp_clear = 1'b0;
      // Straps are caught on the first edge after release and then
      // frozen; later switch moves wait for the next reset
      if (!st.loaded) begin
         next_st.loaded  = 1'b1;
         next_st.level   = LEVEL_W'(level_sw) + LEVEL_STEP;
         next_st.offset  = offset_sw;
         next_st.io_base = BASE_W'(BASE_W'(offset_sw) * IO_STEP);
         next_st.role    = cfg_sw[SW_ROLE_POS];
         next_st.follow  = cfg_sw[SW_FOLLOW_POS];
         next_st.port_en = cfg_sw[SW_ROLE_POS];
         next_st.ref_use = cfg_sw[SW_ROLE_POS];
         next_st.xp_valid = 1'b1;
      end
      // Connections: refresh restores them, a followed reset drops
      // them; the drop wins so a stale map is never shown as live
      if (st.loaded && refresh_any) begin
         next_st.xp_valid = 1'b1;
      end
      if (clear_hit) begin
         next_st.xp_clear = 1'b1;
         next_st.xp_valid = 1'b0;
      end
      // Read data stands only in the cycle after the strobe
      next_st.rdata = DATA_RST;
      if (reg_rd) begin
         case (reg_addr)
            REG_CONFIG: begin
               next_st.rdata[CFG_LEVEL_LSB +: LEVEL_W] = st.level;
               next_st.rdata[CFG_OFFSET_LSB +: SW_W]   = st.offset;
               next_st.rdata[CFG_ROLE_BIT]             = st.role;
               next_st.rdata[CFG_FOLLOW_BIT]           = st.follow;
            end
            REG_BASE: begin
               next_st.rdata[BASE_W-1:0] = st.io_base;
            end
            REG_STATUS: begin
               next_st.rdata[STS_VALID_BIT]   = st.xp_valid;
               next_st.rdata[STS_PENDING_BIT] = sched_pending;
               next_st.rdata[STS_LOADED_BIT]  = st.loaded;
               next_st.rdata[STS_PORTS_BIT]   = st.port_en;
            end
            default: begin
               next_st.rdata = DATA_RST; // CONTROL and holes read zero
            end
         endcase
      end
   end

   // State register
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         st         <= '0;
         st.level   <= LEVEL_RST;
         st.io_base <= BASE_RST;
         st.rdata   <= DATA_RST;
      end else begin
         st <= next_st;
      end
   end

   // Take timing follows the reference only in the controller role
   crdec_take_sched u_sched (
      .clk_sys   (clk_sys),
      .nrst      (nrst),
      .enable    (st.loaded),
      .sync_mode (st.ref_use),
      .take_req  (take_any),
      .vi_pulse  (vi_pulse),
      .take      (sched_take),
      .pending   (sched_pending)
   );

   // Outputs straight from flops
   assign reg_rdata               = st.rdata;
   assign level                   = st.level;
   assign io_base                 = st.io_base;
   assign ctrl_role               = st.role;
   assign crosspoint_reset_follow = st.follow;
   assign ctrl_port_en            = st.port_en;
   assign ref_in_use              = st.ref_use;
   assign cfg_loaded              = st.loaded;
   assign xp_clear                = st.xp_clear;
   assign xp_valid                = st.xp_valid;
   assign xp_take                 = sched_take;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!nrst);

   // Level is the binary switch code plus one
   chk_level_decode: assert property (
      $rose(cfg_loaded) |-> level == LEVEL_W'($past(level_sw)) + 5'h01)
      else $error("level not decoded as code plus one");

   // Settings never move once loaded
   chk_straps_hold: assert property (
      (cfg_loaded && $past(cfg_loaded)) |->
         ($stable(level) && $stable(io_base) && $stable(ctrl_role)
          && $stable(crosspoint_reset_follow)))
      else $error("strap settings changed while running");

   // Crosspoint-only role keeps the control ports shut
   chk_ports_off: assert property (
      (cfg_loaded && !ctrl_role) |-> !ctrl_port_en)
      else $error("control port enabled in crosspoint-only role");

   // Controller role opens the control ports
   chk_ports_on: assert property (
      (cfg_loaded && ctrl_role) |-> ctrl_port_en)
      else $error("control port disabled in controller role");

   // Role and follow come from positions 7 and 8
   chk_strap_pos: assert property (
      $rose(cfg_loaded) |->
         (ctrl_role == $past(cfg_sw[6])
          && crosspoint_reset_follow == $past(cfg_sw[7])))
      else $error("role or follow taken from wrong switch");

   // Followed controller reset drops all connections until refresh; a
   // reset repeated in the next cycle may stretch the clear pulse
   chk_clear_follow: assert property (
      (cfg_loaded && ctrl_role && crosspoint_reset_follow && crst_any)
         |=> (xp_clear && !xp_valid) ##1 (!xp_clear || $past(clear_hit)))
      else $error("controller reset did not clear crosspoints");

   // Without follow a controller reset leaves connections alone
   chk_keep_nofollow: assert property (
      (cfg_loaded && !crosspoint_reset_follow && crst_any && xp_valid)
         |=> (!xp_clear && xp_valid))
      else $error("crosspoints lost with follow off");

   // Crosspoint-only cards ignore the follow switch
   chk_follow_ignored: assert property (
      (cfg_loaded && !ctrl_role && crst_any) |=> !xp_clear)
      else $error("follow honoured outside controller role");

   // Reference use tracks the role exactly
   chk_ref_role: assert property (
      cfg_loaded |-> (ref_in_use == ctrl_role))
      else $error("sync reference use does not match role");

   // Base number is 32 times the offset setting
   chk_offset_base: assert property (
      $rose(cfg_loaded) |->
         io_base == BASE_W'(BASE_W'($past(offset_sw)) * 9'h020))
      else $error("io base not 32 times offset setting");

   // Refresh brings connections back when no reset collides
   chk_refresh_valid: assert property (
      (cfg_loaded && refresh_any && !clear_hit) |=> xp_valid)
      else $error("refresh did not restore connections");

   // Read data lives for exactly one cycle
   chk_rdata_pulse: assert property (
      !reg_rd |=> (reg_rdata == 32'h0000_0000))
      else $error("read data present without a read");

endmodule // crdec_core

// ---- crdec_pkg.sv ----
package crdec_pkg;

   // Register bus geometry
   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;

   // Register byte offsets
   localparam logic [3:0] REG_CONFIG  = 4'h0;
   localparam logic [3:0] REG_BASE    = 4'h4;
   localparam logic [3:0] REG_STATUS  = 4'h8;
   localparam logic [3:0] REG_CONTROL = 4'hC;

   // CONFIG fields
   localparam int CFG_LEVEL_LSB  = 0;
   localparam int CFG_OFFSET_LSB = 8;
   localparam int CFG_ROLE_BIT   = 16;
   localparam int CFG_FOLLOW_BIT = 17;

   // STATUS fields
   localparam int STS_VALID_BIT   = 0;
   localparam int STS_PENDING_BIT = 1;
   localparam int STS_LOADED_BIT  = 2;
   localparam int STS_PORTS_BIT   = 3;

   // CONTROL fields (write only, each a one-shot command)
   localparam int CTL_CRST_BIT    = 0;
   localparam int CTL_REFRESH_BIT = 1;
   localparam int CTL_TAKE_BIT    = 2;

   // Switch bank layout: position n sits in bit n-1
   localparam int SW_W          = 4;
   localparam int SW_ROLE_POS   = 6;
   localparam int SW_FOLLOW_POS = 7;

   // Decoded widths and steps
   localparam int LEVEL_W = 5;
   localparam int BASE_W  = 9;
   localparam logic [LEVEL_W-1:0] LEVEL_STEP = 5'h01;
   localparam logic [BASE_W-1:0]  IO_STEP    = 9'h020;

   // Reset values
   localparam logic [LEVEL_W-1:0] LEVEL_RST = 5'h00;
   localparam logic [BASE_W-1:0]  BASE_RST  = 9'h000;
   localparam logic [DATA_W-1:0]  DATA_RST  = 32'h0000_0000;

endpackage

// ---- crdec_take_sched.sv ----
`timescale 1ns/1ps

// Times crosspoint takes: held for the vertical interval in sync mode,
// passed on at once otherwise.
module crdec_take_sched (
   input  wire logic clk_sys,
   input  wire logic nrst,
   input  wire logic enable,
   input  wire logic sync_mode,
   input  wire logic take_req,
   input  wire logic vi_pulse,
   output logic      take,
   output logic      pending
);

   typedef struct packed {
      logic take;
      logic pending;
   } crdec_sched_s;

   crdec_sched_s st;
   crdec_sched_s next_st;

   // A request arriving on a vertical-interval cycle is taken in that
   // interval rather than waiting a whole field
   always_comb begin
      next_st = st;
      next_st.take = 1'b0;
      if (!enable) begin
         next_st.pending = 1'b0;
      end else if (sync_mode) begin
         if (vi_pulse && (st.pending || take_req)) begin
            next_st.take    = 1'b1;
            next_st.pending = 1'b0;
         end else if (take_req) begin
            next_st.pending = 1'b1;
         end
      end else begin
         next_st.take    = take_req;
         next_st.pending = 1'b0;
      end
   end

   // State register
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign take    = st.take;
   assign pending = st.pending;

   // Sync mode never switches outside the vertical interval
   chk_take_wait_vi: assert property (@(posedge clk_sys) disable iff (!nrst)
      (enable && sync_mode && !vi_pulse) |=> !take)
      else $error("take issued outside vertical interval");

   // Sync mode switches in the interval once a take is waiting
   chk_take_on_vi: assert property (@(posedge clk_sys) disable iff (!nrst)
      (enable && sync_mode && vi_pulse && (pending || take_req)) |=> take)
      else $error("waiting take missed the vertical interval");

   // Without the reference a take passes in the very next cycle
   chk_take_free: assert property (@(posedge clk_sys) disable iff (!nrst)
      (enable && !sync_mode && take_req) |=> take ##1 !pending)
      else $error("free-running take not issued");

endmodule // crdec_take_sched

// ---- crdec_ctrl_model.sv ----
`timescale 1ns/1ps

// Stand-in for the system controller and the reference feed: it pulses
// controller resets, take requests and vertical-interval markers.
module crdec_ctrl_model (
   input  wire logic clk_sys,
   output logic      ctrl_rst_evt,
   output logic      take_req,
   output logic      vi_pulse
);

   // Idle low from time zero so nothing fires while straps load
   initial begin
      ctrl_rst_evt = 1'b0;
      take_req     = 1'b0;
      vi_pulse     = 1'b0;
   end

   // One-cycle pulse: 0 controller reset, 1 take, 2 reference marker
   task automatic pulse(input int sel);
      @(posedge clk_sys) begin
         ctrl_rst_evt <= (sel == 0);
         take_req     <= (sel == 1);
         vi_pulse     <= (sel == 2);
      end
      @(posedge clk_sys) begin
         ctrl_rst_evt <= 1'b0;
         take_req     <= 1'b0;
         vi_pulse     <= 1'b0;
      end
      #1;
   endtask

endmodule // crdec_ctrl_model

// ---- crdec_core_tb_top.sv ----
`timescale 1ns/1ps

module crdec_core_tb_top;
   import crdec_pkg::*;

   typedef struct {
      logic [3:0] lv;
      logic [3:0] of;
      logic       role;
      logic       fol;
      logic [4:0] lvl;
      logic [8:0] base;
   } crdec_row_s;

   logic              clk_sys, nrst;
   logic [3:0]        level_sw, offset_sw, reg_addr;
   logic [7:0]        cfg_sw;
   logic              ctrl_rst_evt, take_req, vi_pulse, reg_wr, reg_rd;
   logic [31:0]       reg_wdata, reg_rdata;
   logic [4:0]        level;
   logic [8:0]        io_base;
   logic              ctrl_role, crosspoint_reset_follow, ctrl_port_en;
   logic              ref_in_use, cfg_loaded, xp_clear, xp_valid, xp_take;
   int                n_fail, cmp_count;
   crdec_row_s        rows [5];

   crdec_core u_crdec_core (.clk_sys(clk_sys), .nrst(nrst),
      .level_sw(level_sw), .offset_sw(offset_sw), .cfg_sw(cfg_sw),
      .ctrl_rst_evt(ctrl_rst_evt), .take_req(take_req),
      .vi_pulse(vi_pulse), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .level(level), .io_base(io_base), .ctrl_role(ctrl_role),
      .crosspoint_reset_follow(crosspoint_reset_follow),
      .ctrl_port_en(ctrl_port_en), .ref_in_use(ref_in_use),
      .cfg_loaded(cfg_loaded), .xp_clear(xp_clear), .xp_valid(xp_valid),
      .xp_take(xp_take));

   crdec_ctrl_model u_crdec_ctrl_model (.clk_sys(clk_sys),
      .ctrl_rst_evt(ctrl_rst_evt), .take_req(take_req),
      .vi_pulse(vi_pulse));

   // 20 MHz card clock
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   task automatic chk(input string nm, input logic [31:0] exp,
                      input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         $display("Error %s expected %h seen %h", nm, exp, got);
         n_fail++;
      end
   endtask

   task automatic end_sim();
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Register write; returns just after the strobe edge
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys) begin
         reg_wr    <= 1'b1;
         reg_addr  <= a;
         reg_wdata <= d;
      end
      @(posedge clk_sys) reg_wr <= 1'b0;
      #1;
   endtask

   // Register read; returns in the cycle that carries the data
   task automatic rd(input logic [3:0] a);
      @(posedge clk_sys) begin
         reg_rd   <= 1'b1;
         reg_addr <= a;
      end
      @(posedge clk_sys) reg_rd <= 1'b0;
      #1;
   endtask

   // Short card reset; returns once the first edge after release loaded
   task automatic do_reset();
      @(posedge clk_sys) nrst <= 1'b0;
      repeat (2) @(posedge clk_sys);
      nrst <= 1'b1;
      @(posedge clk_sys);
      #1;
   endtask

   // Watchdog: the whole run needs well under 1000 cycles
   initial begin
      #200000;
      n_fail++;
      end_sim();
   end

   initial begin
      rows[0] = '{4'h0, 4'h0, 1'b0, 1'b0, 5'h01, 9'h000};
      rows[1] = '{4'hF, 4'hF, 1'b1, 1'b1, 5'h10, 9'h1E0};
      rows[2] = '{4'h5, 4'hA, 1'b1, 1'b0, 5'h06, 9'h140};
      rows[3] = '{4'hA, 4'h5, 1'b0, 1'b1, 5'h0B, 9'h0A0};
      rows[4] = '{4'h1, 4'h1, 1'b1, 1'b1, 5'h02, 9'h020};
      n_fail = 0;
      cmp_count = 0;
      nrst = 1'b0;
      level_sw = 4'h3;
      offset_sw = 4'h3;
      cfg_sw = 8'hC0;
      reg_addr = 4'h0;
      reg_wdata = 32'h0000_0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      repeat (19) @(posedge clk_sys);
      #1;
      chk("level_in_reset", 32'h0, level);
      chk("valid_in_reset", 32'h0, xp_valid);
      @(posedge clk_sys) nrst <= 1'b1;
      // Each row: straps, reset, decode, followed reset, refresh, take
      for (int i = 0; i < 5; i++) begin
         level_sw  <= rows[i].lv;
         offset_sw <= rows[i].of;
         cfg_sw    <= {rows[i].fol, rows[i].role, 6'h00};
         do_reset();
         chk("level", rows[i].lvl, level);
         chk("io_base", rows[i].base, io_base);
         chk("ctrl_port_en", rows[i].role, ctrl_port_en);
         chk("ref_in_use", rows[i].role, ref_in_use);
         chk("follow", rows[i].fol, crosspoint_reset_follow);
         chk("ctrl_role", rows[i].role, ctrl_role);
         chk("cfg_loaded", 32'h1, cfg_loaded);
         rd(REG_CONFIG);
         chk("config", {14'h0, rows[i].fol, rows[i].role, 4'h0,
             rows[i].of, 3'h0, rows[i].lvl}, reg_rdata);
         rd(REG_STATUS);
         chk("status", {28'h0, rows[i].role, 3'h5}, reg_rdata);
         u_crdec_ctrl_model.pulse(0);
         chk("xp_clear", rows[i].role & rows[i].fol, xp_clear);
         chk("xp_valid", !(rows[i].role & rows[i].fol), xp_valid);
         wr(REG_CONTROL, 32'h0000_0002);
         chk("xp_valid_refresh", 32'h1, xp_valid);
         u_crdec_ctrl_model.pulse(1);
         chk("xp_take_early", !rows[i].role, xp_take);
         if (rows[i].role) begin
            u_crdec_ctrl_model.pulse(2);
            chk("xp_take_vi", 32'h1, xp_take);
         end
      end
      // Two takes before one marker merge into a single switch
      u_crdec_ctrl_model.pulse(1);
      rd(REG_STATUS);
      chk("status_pending", 32'hF, reg_rdata);
      wr(REG_CONTROL, 32'h0000_0004);
      u_crdec_ctrl_model.pulse(2);
      chk("take_merged", 32'h1, xp_take);
      @(posedge clk_sys);
      #1;
      chk("take_once", 32'h0, xp_take);
      // Controller reset by command; a refresh in the same write loses
      wr(REG_CONTROL, 32'h0000_0001);
      chk("cmd_clear", 32'h1, xp_clear);
      chk("cmd_valid", 32'h0, xp_valid);
      wr(REG_CONTROL, 32'h0000_0003);
      chk("clear_wins", 32'h0, xp_valid);
      wr(REG_CONTROL, 32'h0000_0002);
      chk("valid_back", 32'h1, xp_valid);
      // Straps moved while running are ignored until the next reset
      level_sw  <= 4'h9;
      offset_sw <= 4'h7;
      cfg_sw    <= 8'h00;
      repeat (4) @(posedge clk_sys);
      #1;
      chk("level_held", 32'h02, level);
      chk("role_held", 32'h1, ctrl_role);
      // Read-only, write-only and unmapped places
      wr(REG_BASE, 32'hFFFF_FFFF);
      rd(REG_BASE);
      chk("base_reg", 32'h020, reg_rdata);
      @(posedge clk_sys);
      #1;
      chk("rdata_idle", 32'h0, reg_rdata);
      rd(REG_CONTROL);
      chk("control_read", 32'h0, reg_rdata);
      rd(4'h6);
      chk("unmapped_read", 32'h0, reg_rdata);
      do_reset();
      chk("level_new", 32'h0A, level);
      chk("ports_off", 32'h0, ctrl_port_en);
      end_sim();
   end

endmodule // crdec_core_tb_top
